/* File: common/ext_params.svh */
// Constants for the extended instruction decoder
`ifndef EXT_PARAMS_SVH
`define EXT_PARAMS_SVH
`define PTR_W 12
`define PC_W 21
`define OPC_ADD_PTR 8'he8
`define OPC_SUB_PTR 8'he9
`define OPC_PUSH_LIT 8'hea
`define OPC_MOVE_IDX 8'heb
`define OPC_CALL_ACC 16'h0014
`define WORD2_PREFIX 4'hf
`define SEL_FRAME 2'h3
`define SEL_STACK_PTR 2'h2
`define PC_RET_STEP 21'h000002
`define PUSH_STEP 8'h01
`define IDX_LIMIT 8'h5f
`define ZERO_BYTE 8'h00
`define IND_PAGE 4'hf
`define IND0_HI 8'hef
`define IND0_LO 8'heb
`define IND1_HI 8'he7
`define IND1_LO 8'he3
`define IND2_HI 8'hdf
`define IND2_LO 8'hdb
`define FILE_OP_LO 4'h1
`define FILE_OP_HI 4'hb
`define ZERO_NIBBLE 4'h0
`define FILE_OP0_MASK 6'h00
`define FILE_OP1_MASK 6'h01
`endif

/* File: common/ext_pkg.sv */
// Types shared by the extended instruction decoder
package ext_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_WORD2, ST_NOP} state_t;
   typedef logic [11:0] ptr_t;
   typedef logic [20:0] pc_t;
endpackage : ext_pkg

/* File: common/ext_idx_if.sv */
// Index address request and answer between decoder and index unit
`timescale 1ns/1ps
interface ext_idx_if;
   logic [11:0] base;
   logic [7:0] offset;
   logic [11:0] addr;
   logic indirect;
   modport requester (output base, output offset, input addr, input indirect);
   modport unit (input base, input offset, output addr, output indirect);
endinterface : ext_idx_if

/* File: src/ext_index_unit.sv */
// Frame-relative address and indirect register detection
`timescale 1ns/1ps
`include "ext_params.svh"
module ext_index_unit
   import ext_pkg::*;
(
   ext_idx_if.unit idx
);
   function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction : in_range

   always_comb
   begin
      idx.addr = idx.base + {4'h0, idx.offset};
      idx.indirect = (idx.addr[11:8] == `IND_PAGE) &&
                     (in_range(idx.addr[7:0], `IND0_LO, `IND0_HI) ||
                      in_range(idx.addr[7:0], `IND1_LO, `IND1_HI) ||
                      in_range(idx.addr[7:0], `IND2_LO, `IND2_HI));
   end
endmodule : ext_index_unit

/* File: src/ext_ptr_unit.sv */
// Pointer add or subtract of an unsigned literal
`timescale 1ns/1ps
`include "ext_params.svh"
module ext_ptr_unit
   import ext_pkg::*;
(
   // Operands
   input wire logic [11:0] base_i,
   input wire logic [7:0] amount_i,
   input wire logic sub_i,
   // Result
   output logic [11:0] result_o
);
   // Wraps within the 12-bit data space, as the pointer itself does
   always_comb
   begin
      if (sub_i)
         result_o = base_i - {4'h0, amount_i};
      else
         result_o = base_i + {4'h0, amount_i};
   end
endmodule : ext_ptr_unit

/* File: src/ext_decoder.sv */
// Decode and execute logic for the eight extension instructions
// Operation
// - Extension and indexed addressing work only with the enable bit set
// - Exactly eight added literal instructions on pointers or indexed access
// - Enabled extension applies indexed offset addressing to standard file ops
// - Pointer add/sub literal: 6-bit literal on pointer 0..2, one cycle
// - Add literal with select 11 is frame add and return
// - Subtract literal with select 11 is frame subtract and return
// - Frame ops then load pc from return stack top; two cycles, second idle
// - Opcode 0014h is call via accumulator, two cycles, flags unchanged
// - Call via accumulator first pushes pc plus 2 on return stack
// - Then pc low byte takes the working accumulator
// - Then pc high and upper bytes take the two pc latches
// - Second cycle of call via accumulator is idle during refetch
// - Call via accumulator saves no accumulator, status or bank holder
// - Push literal writes at frame pointer then decrements it, one cycle
// - Indexed-to-absolute move: two words, frame plus offset to 12-bit address
// - Indexed-to-indexed move: two words, both frame plus 7-bit offset
// - Access bit clear and file operand up to 95 uses indexed addressing
// - Indexed move reading an indirect register gets 00h
// - Indexed move writing an indirect register does nothing
`timescale 1ns/1ps
`include "ext_params.svh"
module ext_decoder
   import ext_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Configuration
   input wire logic extension_enable_bit_i,
   // Instruction fetch
   input wire logic instr_valid_i,
   input wire logic [15:0] instr_i,
   input wire logic [20:0] pc_i,
   output logic ready_o,
   output logic word2_wait_o,
   // Core state
   input wire logic [7:0] working_accumulator_i,
   input wire logic [7:0] pc_high_latch_i,
   input wire logic [4:0] pc_upper_latch_i,
   input wire logic [20:0] top_of_return_stack_i,
   input wire logic [11:0] ptr0_i,
   input wire logic [11:0] ptr1_i,
   input wire logic [11:0] stack_frame_pointer_i,
   // Pointer write
   output logic ptr_wr_o,
   output logic [1:0] ptr_sel_o,
   output logic [11:0] ptr_data_o,
   // Program counter and return stack
   output logic stack_push_o,
   output logic [20:0] stack_push_data_o,
   output logic pc_load_o,
   output logic [20:0] pc_load_data_o,
   // Data memory
   output logic mem_rd_o,
   output logic [11:0] mem_raddr_o,
   input wire logic [7:0] mem_rdata_i,
   output logic mem_wr_o,
   output logic [11:0] mem_waddr_o,
   output logic [7:0] mem_wdata_o,
   // Execution status
   output logic ext_hit_o,
   output logic status_keep_o,
   output logic idx_mode_o,
   output logic [11:0] idx_addr_o
);
   state_t state_reg;
   logic move_to_idx_reg;
   logic take;
   logic is_add;
   logic is_sub;
   logic is_push;
   logic is_move;
   logic is_call;
   logic ext_take;
   logic word2_take;
   logic frame_sel;
   logic std_idx;
   logic [11:0] sel_ptr;
   logic [7:0] ptr_amount;
   logic ptr_is_sub;
   logic [11:0] ptr_result;

   ext_idx_if idx ();

   ext_index_unit u_index (
      .idx (idx.unit)
   );

   ext_ptr_unit u_ptr (
      .base_i (sel_ptr),
      .amount_i (ptr_amount),
      .sub_i (ptr_is_sub),
      .result_o (ptr_result)
   );

   // Byte or bit oriented standard instruction carrying an access bit
   function automatic logic is_file_op(input logic [15:0] w);
      is_file_op = ((w[15:12] >= `FILE_OP_LO) && (w[15:12] <= `FILE_OP_HI)) ||
                   ((w[15:10] == `FILE_OP0_MASK) && w[9]) ||
                   (w[15:10] == `FILE_OP1_MASK);
   endfunction : is_file_op

   function automatic logic [11:0] pick_ptr(input logic [1:0] s, input logic [11:0] p0,
                                            input logic [11:0] p1, input logic [11:0] p2);
      case (s)
         2'h0: pick_ptr = p0;
         2'h1: pick_ptr = p1;
         default: pick_ptr = p2;
      endcase
   endfunction : pick_ptr

   // Decode
   always_comb
   begin
      take = instr_valid_i && (state_reg == ST_IDLE);
      is_add = instr_i[15:8] == `OPC_ADD_PTR;
      is_sub = instr_i[15:8] == `OPC_SUB_PTR;
      is_push = instr_i[15:8] == `OPC_PUSH_LIT;
      is_move = instr_i[15:8] == `OPC_MOVE_IDX;
      is_call = instr_i == `OPC_CALL_ACC;
      ext_take = take && extension_enable_bit_i &&
                 (is_add || is_sub || is_push || is_move || is_call);
      word2_take = instr_valid_i && (state_reg == ST_WORD2);
      frame_sel = instr_i[7:6] == `SEL_FRAME;
      std_idx = take && extension_enable_bit_i && is_file_op(instr_i) && !instr_i[8] &&
                (instr_i[7:0] <= `IDX_LIMIT);
   end

   // Pointer arithmetic operand selection
   always_comb
   begin
      sel_ptr = frame_sel ? stack_frame_pointer_i
                          : pick_ptr(instr_i[7:6], ptr0_i, ptr1_i, stack_frame_pointer_i);
      ptr_amount = {2'h0, instr_i[5:0]};
      ptr_is_sub = is_sub;
      if (is_push)
      begin
         sel_ptr = stack_frame_pointer_i;
         ptr_amount = `PUSH_STEP;
         ptr_is_sub = 1'b1;
      end
   end

   // Index unit: source offset in word one, destination in word two, file operand else
   always_comb
   begin
      idx.base = stack_frame_pointer_i;
      if (state_reg == ST_WORD2)
         idx.offset = {1'b0, instr_i[6:0]};
      else if (is_move)
         idx.offset = {1'b0, instr_i[6:0]};
      else
         idx.offset = instr_i[7:0];
   end

   assign ready_o = state_reg != ST_NOP;
   assign word2_wait_o = state_reg == ST_WORD2;

   // Sequencing: second cycles and second words
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         state_reg <= ST_IDLE;
      else
         case (state_reg)
            ST_IDLE:
               if (ext_take && (is_call || ((is_add || is_sub) && frame_sel)))
                  state_reg <= ST_NOP;
               else if (ext_take && is_move)
                  state_reg <= ST_WORD2;
            ST_WORD2:
               if (word2_take)
                  state_reg <= ST_IDLE;
            ST_NOP:
               state_reg <= ST_IDLE;
            default:
               state_reg <= ST_IDLE;
         endcase
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         move_to_idx_reg <= 1'b0;
      else if (ext_take && is_move)
         move_to_idx_reg <= instr_i[7];
   end

   // Pointer updates
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ptr_wr_o <= 1'b0;
         ptr_sel_o <= 2'h0;
         ptr_data_o <= 12'h000;
      end
      else
      begin
         ptr_wr_o <= ext_take && (is_add || is_sub || is_push);
         ptr_sel_o <= (is_push || frame_sel) ? `SEL_STACK_PTR : instr_i[7:6];
         ptr_data_o <= ptr_result;
      end
   end

   // Program counter and return stack: the call saves nothing else
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stack_push_o <= 1'b0;
         stack_push_data_o <= 21'h000000;
         pc_load_o <= 1'b0;
         pc_load_data_o <= 21'h000000;
      end
      else
      begin
         stack_push_o <= ext_take && is_call;
         stack_push_data_o <= pc_i + `PC_RET_STEP;
         pc_load_o <= ext_take && (is_call || ((is_add || is_sub) && frame_sel));
         if (is_call)
            pc_load_data_o <= {pc_upper_latch_i, pc_high_latch_i,
                               working_accumulator_i};
         else
            pc_load_data_o <= top_of_return_stack_i;
      end
   end

   // Data memory reads for moves; an indirect source is never touched
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mem_rd_o <= 1'b0;
         mem_raddr_o <= 12'h000;
      end
      else if (ext_take && is_move)
      begin
         mem_rd_o <= !idx.indirect;
         mem_raddr_o <= idx.addr;
      end
      else if (word2_take)
         mem_rd_o <= 1'b0;
   end

   // Data memory writes: push literal and move completion
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mem_wr_o <= 1'b0;
         mem_waddr_o <= 12'h000;
         mem_wdata_o <= 8'h00;
      end
      else if (ext_take && is_push)
      begin
         mem_wr_o <= 1'b1;
         mem_waddr_o <= stack_frame_pointer_i;
         mem_wdata_o <= instr_i[7:0];
      end
      else if (word2_take)
      begin
         mem_wr_o <= !(move_to_idx_reg && idx.indirect);
         mem_waddr_o <= move_to_idx_reg ? idx.addr : instr_i[11:0];
         mem_wdata_o <= mem_rd_o ? mem_rdata_i : `ZERO_BYTE;
      end
      else
         mem_wr_o <= 1'b0;
   end

   // Execution status toward the core
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ext_hit_o <= 1'b0;
         status_keep_o <= 1'b0;
      end
      else
      begin
         ext_hit_o <= ext_take || word2_take;
         status_keep_o <= ext_take || word2_take;
      end
   end

   // Standard instructions rewritten to frame-relative addresses
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         idx_mode_o <= 1'b0;
         idx_addr_o <= 12'h000;
      end
      else
      begin
         idx_mode_o <= std_idx;
         idx_addr_o <= idx.addr;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_disabled_no_hit: assert property (
      !extension_enable_bit_i && take |=> !ext_hit_o && !idx_mode_o)
      else $error("extension acted while disabled");

   a_ptr_add_value: assert property (
      ext_take && is_add && !frame_sel |=>
         ptr_wr_o && ptr_data_o == $past(sel_ptr) + {6'h00, $past(instr_i[5:0])})
      else $error("pointer add result wrong");

   a_frame_return_two: assert property (
      ext_take && (is_add || is_sub) && frame_sel |=>
         pc_load_o && ptr_sel_o == `SEL_STACK_PTR && !ready_o ##1 ready_o && !pc_load_o)
      else $error("frame return sequence wrong");

   a_call_push_pc: assert property (
      ext_take && is_call |=> stack_push_o && stack_push_data_o == $past(pc_i) + `PC_RET_STEP)
      else $error("call return address wrong");

   a_call_target: assert property (
      ext_take && is_call |=> pc_load_data_o ==
         {$past(pc_upper_latch_i), $past(pc_high_latch_i), $past(working_accumulator_i)})
      else $error("call target wrong");

   a_call_idle_cycle: assert property (
      ext_take && is_call |=> !ready_o ##1 !pc_load_o && !stack_push_o && !ptr_wr_o)
      else $error("call second cycle not idle");

   a_push_write: assert property (
      ext_take && is_push |=> mem_wr_o && mem_wdata_o == $past(instr_i[7:0]) &&
         mem_waddr_o == $past(stack_frame_pointer_i) &&
         ptr_data_o == $past(stack_frame_pointer_i) - 12'h001)
      else $error("push literal wrong");

   a_move_waits_word: assert property (
      ext_take && is_move |=> word2_wait_o && !mem_wr_o)
      else $error("move did not wait for second word");

   a_move_zero_src: assert property (
      word2_take && !mem_rd_o |=> mem_wdata_o == `ZERO_BYTE)
      else $error("indirect source not read as zero");

   a_move_dst_nop: assert property (
      word2_take && move_to_idx_reg && idx.indirect |=> !mem_wr_o)
      else $error("indirect destination written");

   a_std_index: assert property (
      take && extension_enable_bit_i && is_file_op(instr_i) && !instr_i[8] &&
         instr_i[7:0] > `IDX_LIMIT |=> !idx_mode_o)
      else $error("indexed mode above limit");

   a_word2_consumed: assert property (
      word2_take |=> ext_hit_o && status_keep_o && !ptr_wr_o && !pc_load_o)
      else $error("second word executed on its own");
endmodule : ext_decoder

/* File: verification/ext_core_model.sv */
// Data memory model standing on the far side of the decoder
`timescale 1ns/1ps
module ext_core_model
(
   // Clock
   input wire logic clk_i,
   // Data memory
   input wire logic mem_rd_i,
   input wire logic [11:0] mem_raddr_i,
   output logic [7:0] mem_rdata_o,
   input wire logic mem_wr_i,
   input wire logic [11:0] mem_waddr_i,
   input wire logic [7:0] mem_wdata_i
);
   logic [7:0] mem_reg [4096];
   logic [7:0] last_reg;
   initial
   begin
      for (int i = 0; i < 4096; i++)
         mem_reg[i] = i[7:0] ^ 8'h5a;
      last_reg = 8'h00;
   end
   // Outside a read the bus shows the inverse of the last value, so stale data cannot pass
   always_comb
      mem_rdata_o = mem_rd_i ? mem_reg[mem_raddr_i] : ~last_reg;
   always @(posedge clk_i)
   begin
      if (mem_rd_i)
         last_reg <= mem_reg[mem_raddr_i];
      if (mem_wr_i)
         mem_reg[mem_waddr_i] <= mem_wdata_i;
   end
endmodule : ext_core_model

/* File: verification/extended_instruction_decode_tb.sv */
// Self-checking bench for the extension decoder
`timescale 1ns/1ps
module extended_instruction_decode_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic en_i = 1'b1;
   logic valid_i = 1'b0;
   logic [15:0] instr_i = 16'h0000;
   logic [20:0] pc_i = 21'h000100;
   logic [7:0] acc_i = 8'h06;
   logic [7:0] lath_i = 8'h10;
   logic [4:0] latu_i = 5'h01;
   logic [20:0] tos_i = 21'h001234;
   logic [11:0] ptr0_i = 12'h100;
   logic [11:0] ptr1_i = 12'h3ff;
   logic [11:0] sfp_i = 12'h1ec;
   logic [7:0] rdata;
   logic ready_o, wait_o, ptr_wr_o, push_o, pc_load_o, mem_rd_o, mem_wr_o, hit_o, keep_o, idx_o;
   logic [1:0] sel_o;
   logic [11:0] ptr_data_o, raddr_o, waddr_o, idx_addr_o;
   logic [20:0] push_data_o, pc_data_o;
   logic [7:0] wdata_o;
   int n_mismatch = 0;
   int checks_done = 0;

   always #50 clk_i = ~clk_i;

   ext_decoder u_dut (.clk_i(clk_i), .rst_i(rst_i), .extension_enable_bit_i(en_i),
      .instr_valid_i(valid_i), .instr_i(instr_i), .pc_i(pc_i), .ready_o(ready_o),
      .word2_wait_o(wait_o), .working_accumulator_i(acc_i), .pc_high_latch_i(lath_i),
      .pc_upper_latch_i(latu_i), .top_of_return_stack_i(tos_i), .ptr0_i(ptr0_i),
      .ptr1_i(ptr1_i), .stack_frame_pointer_i(sfp_i), .ptr_wr_o(ptr_wr_o), .ptr_sel_o(sel_o),
      .ptr_data_o(ptr_data_o), .stack_push_o(push_o), .stack_push_data_o(push_data_o),
      .pc_load_o(pc_load_o), .pc_load_data_o(pc_data_o), .mem_rd_o(mem_rd_o),
      .mem_raddr_o(raddr_o), .mem_rdata_i(rdata), .mem_wr_o(mem_wr_o), .mem_waddr_o(waddr_o),
      .mem_wdata_o(wdata_o), .ext_hit_o(hit_o), .status_keep_o(keep_o), .idx_mode_o(idx_o),
      .idx_addr_o(idx_addr_o));

   ext_core_model u_core (.clk_i(clk_i), .mem_rd_i(mem_rd_o), .mem_raddr_i(raddr_o),
      .mem_rdata_o(rdata), .mem_wr_i(mem_wr_o), .mem_waddr_i(waddr_o), .mem_wdata_i(wdata_o));

   task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
   begin
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   end
   endtask : chk

   // Starts at a falling edge and returns at the next one, where the answer stands
   task automatic send(input logic [15:0] w, input bit hold);
   begin
      valid_i = 1'b1;
      instr_i = w;
      @(negedge clk_i);
      if (!hold)
         valid_i = 1'b0;
   end
   endtask : send

   task automatic t_ptr();
      logic [11:0] base;
      logic [11:0] exp;
   begin
      for (int op = 0; op < 2; op++)
         for (int s = 0; s < 3; s++)
         begin
            base = (s == 0) ? ptr0_i : (s == 1) ? ptr1_i : sfp_i;
            exp = op ? base - 12'h03f : base + 12'h03f;
            send({7'h74, op[0], s[1:0], 6'h3f}, 1'b1);
            chk("ptr_wr", 1, ptr_wr_o);
            chk("ptr_sel", s, sel_o);
            chk("ptr_data", exp, ptr_data_o);
            chk("ext_hit", 1, hit_o);
            chk("status_keep", 1, keep_o);
            chk("ready", 1, ready_o);
         end
   end
   endtask : t_ptr

   task automatic t_frame();
   begin
      for (int op = 0; op < 2; op++)
      begin
         send({7'h74, op[0], 8'hc5}, 1'b1);
         chk("ptr_sel", 2, sel_o);
         chk("ptr_data", op ? sfp_i - 12'h005 : sfp_i + 12'h005, ptr_data_o);
         chk("pc_load", 1, pc_load_o);
         chk("pc_data", tos_i, pc_data_o);
         chk("ready", 0, ready_o);
         chk("status_keep", 1, keep_o);
         instr_i = 16'he841;
         @(negedge clk_i);
         chk("ptr_wr", 0, ptr_wr_o);
         chk("ready", 1, ready_o);
      end
   end
   endtask : t_frame

   task automatic t_call();
   begin
      send(16'h0014, 1'b0);
      chk("push", 1, push_o);
      chk("push_data", pc_i + 21'h000002, push_data_o);
      chk("pc_load", 1, pc_load_o);
      chk("pc_data", {latu_i, lath_i, acc_i}, pc_data_o);
      chk("ready", 0, ready_o);
      chk("side_write", 0, {ptr_wr_o, mem_wr_o});
      chk("status_keep", 1, keep_o);
      @(negedge clk_i);
      chk("pc_load", 0, pc_load_o);
      chk("ready", 1, ready_o);
   end
   endtask : t_call

   task automatic t_push();
   begin
      send(16'hea08, 1'b1);
      chk("mem_wr", 1, mem_wr_o);
      chk("ptr_wr", 1, ptr_wr_o);
      chk("waddr", sfp_i, waddr_o);
      chk("wdata", 8'h08, wdata_o);
      chk("ptr_sel", 2, sel_o);
      chk("ptr_data", sfp_i - 12'h001, ptr_data_o);
   end
   endtask : t_push

   // Reset lands while a move waits for its second word
   task automatic t_reset();
   begin
      send(16'heb05, 1'b1);
      chk("word2_wait", 1, wait_o);
      valid_i = 1'b0;
      rst_i = 1'b1;
      @(negedge clk_i);
      chk("reset_out", 0, {mem_rd_o, wait_o, hit_o, ptr_wr_o});
      chk("ready", 1, ready_o);
      rst_i = 1'b0;
      @(negedge clk_i);
      chk("reset_out", 0, {mem_rd_o, wait_o, hit_o});
   end
   endtask : t_reset

   task automatic t_move(input logic [15:0] w1, input logic [15:0] w2, input logic rd,
      input logic [11:0] ra, input logic wr, input logic [11:0] wa, input logic [7:0] wd);
   begin
      send(w1, 1'b1);
      chk("mem_rd", rd, mem_rd_o);
      if (rd)
         chk("raddr", ra, raddr_o);
      chk("word2_wait", 1, wait_o);
      send(w2, 1'b1);
      chk("mem_rd", 0, mem_rd_o);
      chk("mem_wr", wr, mem_wr_o);
      if (wr)
      begin
         chk("waddr", wa, waddr_o);
         chk("wdata", wd, wdata_o);
      end
      chk("second_word", 0, {ptr_wr_o, idx_o, wait_o});
      chk("ext_hit", 1, hit_o);
   end
   endtask : t_move

   task automatic t_std(input logic [15:0] w, input logic idx, input logic [11:0] addr);
   begin
      send(w, 1'b1);
      chk("idx_mode", idx, idx_o);
      if (idx)
         chk("idx_addr", addr, idx_addr_o);
      chk("ext_hit", 0, hit_o);
   end
   endtask : t_std

   task automatic summarize();
   begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask : summarize

   initial
   begin
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      chk("ready", 1, ready_o);
      t_ptr();
      $display("test pointer done");
      t_frame();
      $display("test frame done");
      t_call();
      $display("test call done");
      t_push();
      $display("test push done");
      t_reset();
      $display("test reset done");
      t_move(16'heb05, 16'hf123, 1, 12'h1f1, 1, 12'h123, 8'hab);
      t_move(16'heb85, 16'hf006, 1, 12'h1f1, 1, 12'h1f2, 8'hab);
      sfp_i = 12'hfd0;
      t_move(16'heb0b, 16'hf123, 0, 12'h000, 1, 12'h123, 8'h00);
      t_move(16'heb85, 16'hf00b, 1, 12'hfd5, 0, 12'h000, 8'h00);
      $display("test move done");
      t_std(16'h2410, 1, 12'hfe0);
      t_std(16'h245f, 1, 12'h02f);
      t_std(16'h2460, 0, 12'h000);
      t_std(16'h2510, 0, 12'h000);
      t_std(16'h0210, 1, 12'hfe0);
      t_std(16'h0410, 1, 12'hfe0);
      en_i = 1'b0;
      send(16'he84a, 1'b1);
      chk("disabled", 0, {hit_o, keep_o, ptr_wr_o});
      t_std(16'h2410, 0, 12'h000);
      $display("test indexed and disabled done");
      summarize();
   end

   // Tests need about forty cycles; this limit of 3000 cycles is far beyond that
   initial
   begin
      #(3000 * 100);
      n_mismatch++;
      summarize();
   end
endmodule : extended_instruction_decode_tb
